// file: pkg/drpc_pkg.sv
/*
  Constants and carrier types for the display rail pulse control block.
  Assumes a 10 MHz system clock; all times are converted to cycle counts here.
*/
`default_nettype none
package drpc_pkg;
  localparam int CLK_KHZ = 10000;
  // times in microseconds as printed, counts derived
  localparam int INIT_US = 300;
  localparam int ACCEPT_MIN_US = 30;
  localparam int SHUT_MIN_US = 30;
  localparam int TRANS_US = 300;
  localparam int NEG_DELAY_US = 10000;
  localparam int RUN_FAULT_US = 3000;
  localparam int POS_CHECK_US = 10000;
  localparam int NEG_SC_CHECK_US = 10000;
  localparam int NEG_REG_CHECK_US = 20000;
  // least times: round up
  localparam int INIT_CYC = (INIT_US * CLK_KHZ + 999) / 1000;
  localparam int ACCEPT_CYC = (ACCEPT_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int SHUT_CYC = (SHUT_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int TRANS_CYC = (TRANS_US * CLK_KHZ + 999) / 1000;
  localparam int NEG_DELAY_CYC = (NEG_DELAY_US * CLK_KHZ + 999) / 1000;
  localparam int RUN_FAULT_CYC = (RUN_FAULT_US * CLK_KHZ + 999) / 1000;
  localparam int POS_CHECK_CYC = (POS_CHECK_US * CLK_KHZ + 999) / 1000;
  localparam int NEG_SC_CHECK_CYC = (NEG_SC_CHECK_US * CLK_KHZ + 999) / 1000;
  localparam int NEG_REG_CHECK_CYC = (NEG_REG_CHECK_US * CLK_KHZ + 999) / 1000;

  // pulse codes
  localparam logic [5:0] CODE_LEVEL_MAX = 6'h1f;
  localparam logic [5:0] CODE_FLOAT = 6'h32;
  localparam logic [5:0] CODE_DISCHARGE = 6'h33;
  // level index: 0 = -4.4 V ... 30 = -1.4 V, step 0.1 V; default -2.2 V
  localparam logic [4:0] LEVEL_DEFAULT = 5'h16;
  localparam logic DISCHARGE_DEFAULT = 1'b1;

  typedef struct packed {
    logic posLow;      // positive rail below 4.1 V
    logic negHigh;     // negative rail 500 mV above 85% of level
    logic posInReg;    // positive rail in regulation
    logic negAboveSc;  // negative rail above start-up short threshold
    logic negInReg;    // negative rail in regulation
  } drpc_sense_t;

  typedef struct packed {
    logic       posEnable;
    logic       posSoftLimit;
    logic       posHighSideOff;
    logic       negEnable;
    logic [4:0] negLevel;
    logic       negRamping;
    logic       dischargeOn;
  } drpc_drive_t;
endpackage
`default_nettype wire

// file: rtl/drpc_core.sv
/*
  Digital control of a dual display supply: single-line pulse counting,
  start-up ordering, short-circuit timers, latched fault and shutdown output mode.
  Assumes all inputs synchronous to clk; analog comparators feed the sense struct.
*/
// Operation
// - line high enables, low disables switching
// - count rising edges as programming code
// - counts 1..31 select -4.4 V to -1.4 V
// - no pulses gives default -2.2 V level
// - 50 floats outputs, 51 discharges, default discharge
// - level change ramps over fast transition time
// - positive rail first, negative 10 ms later
// - positive rail low 3 ms flags fault
// - negative rail high 3 ms flags fault
// - fault shuts down, disconnects, latches
// - fault clears on lockout or line cycle
// - positive rail unregulated at 10 ms faults
// - negative above short threshold at 10 ms faults
// - negative unregulated at 20 ms faults
// - start-up faults latch like run faults
// - start only above lockout with line high
// - input near positive rail disables high-side switch
// - count stored after line high accept period
// - shutdown after line low shutdown period
`timescale 1ns/100ps
`default_nettype none
module drpc_core
  import drpc_pkg::*;
#(
  parameter int INIT_CYCLES = drpc_pkg::INIT_CYC,
  parameter int NEG_DELAY_CYCLES = drpc_pkg::NEG_DELAY_CYC,
  parameter int RUN_FAULT_CYCLES = drpc_pkg::RUN_FAULT_CYC,
  parameter int POS_CHECK_CYCLES = drpc_pkg::POS_CHECK_CYC,
  parameter int NEG_SC_CHECK_CYCLES = drpc_pkg::NEG_SC_CHECK_CYC,
  parameter int NEG_REG_CHECK_CYCLES = drpc_pkg::NEG_REG_CHECK_CYC
) (
  input  wire logic                  clk,          // 10 MHz clock
  input  wire logic                  reset,        // async, active high
  input  wire logic                  ctrlLine,     // host control line
  input  wire logic                  supplyLockout,// input below lockout threshold
  input  wire logic                  nearPosRail,  // input too close to positive rail
  input  wire drpc_pkg::drpc_sense_t sense,        // rail comparators
  output var  drpc_pkg::drpc_drive_t drive,        // converter controls
  output var  logic                  faultLatched, // latched shutdown
  output var  logic                  outputsFloat  // outputs float in shutdown
);
  import drpc_pkg::*;

  typedef enum logic [2:0] {OFF, POS_START, NEG_START, RUN, FAULT} drpc_state_t;

  localparam int CW = 20;

  drpc_state_t state_reg;
  logic        lineDly_reg;
  logic [CW-1:0] seqCnt_reg;      // time since enable
  logic [CW-1:0] lowCnt_reg;      // line low time
  logic [CW-1:0] highCnt_reg;     // line high time
  logic [5:0]  pulseCnt_reg;
  logic        pending_reg;       // edges counted, not yet stored
  logic        stopped_reg;       // shutdown period seen
  logic [4:0]  level_reg;
  logic [4:0]  target_reg;
  logic [CW-1:0] rampCnt_reg;
  logic [CW-1:0] posFltCnt_reg;
  logic [CW-1:0] negFltCnt_reg;
  logic        discharge_reg;

  logic rise;
  logic enabled;
  logic storeNow;
  logic startFault;
  logic runFault;

  assign rise = ctrlLine && !lineDly_reg;
  assign enabled = state_reg != OFF && state_reg != FAULT;
  assign storeNow = pending_reg && ctrlLine && highCnt_reg == CW'(ACCEPT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // line edge and width timers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lineDly_reg <= 1'b0;
    end else begin
      lineDly_reg <= ctrlLine;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      highCnt_reg <= '0;
      lowCnt_reg  <= '0;
      stopped_reg <= 1'b1;
    end else begin
      if (!ctrlLine || rise) highCnt_reg <= '0;
      else if (highCnt_reg != '1) highCnt_reg <= highCnt_reg + 1'b1;
      if (ctrlLine) lowCnt_reg <= '0;
      else if (lowCnt_reg != '1) lowCnt_reg <= lowCnt_reg + 1'b1;
      if (!ctrlLine && lowCnt_reg + 1'b1 >= CW'(SHUT_CYC)) stopped_reg <= 1'b1;
      else if (ctrlLine && stopped_reg) stopped_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and latched fault

  assign startFault =
    (state_reg == NEG_START && seqCnt_reg == CW'(POS_CHECK_CYCLES) && !sense.posInReg) ||
    (state_reg == NEG_START && seqCnt_reg == CW'(NEG_SC_CHECK_CYCLES) && sense.negAboveSc) ||
    (state_reg == NEG_START && seqCnt_reg == CW'(NEG_REG_CHECK_CYCLES) && !sense.negInReg);
  assign runFault = state_reg == RUN &&
    (posFltCnt_reg >= CW'(RUN_FAULT_CYCLES) ||
     negFltCnt_reg >= CW'(RUN_FAULT_CYCLES));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg  <= OFF;
      seqCnt_reg <= '0;
    end else if (supplyLockout) begin
      state_reg  <= OFF;
      seqCnt_reg <= '0;
    end else begin
      if (seqCnt_reg != '1) seqCnt_reg <= seqCnt_reg + 1'b1;
      unique case (state_reg)
        OFF: begin
          if (ctrlLine && stopped_reg) begin
            state_reg  <= POS_START;
            seqCnt_reg <= '0;
          end
        end
        POS_START: begin
          if (stopped_reg) state_reg <= OFF;
          else if (seqCnt_reg + 1'b1 >= CW'(NEG_DELAY_CYCLES)) state_reg <= NEG_START;
        end
        NEG_START: begin
          if (stopped_reg) state_reg <= OFF;
          else if (startFault) state_reg <= FAULT;
          else if (seqCnt_reg >= CW'(NEG_REG_CHECK_CYCLES)) state_reg <= RUN;
        end
        RUN: begin
          if (stopped_reg) state_reg <= OFF;
          else if (runFault) state_reg <= FAULT;
        end
        FAULT: begin
          if (stopped_reg) state_reg <= OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      posFltCnt_reg <= '0;
      negFltCnt_reg <= '0;
    end else begin
      if (state_reg != RUN || !sense.posLow) posFltCnt_reg <= '0;
      else if (posFltCnt_reg != '1) posFltCnt_reg <= posFltCnt_reg + 1'b1;
      if (state_reg != RUN || !sense.negHigh) negFltCnt_reg <= '0;
      else if (negFltCnt_reg != '1) negFltCnt_reg <= negFltCnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse counting and decode

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulseCnt_reg <= '0;
      pending_reg  <= 1'b0;
    end else if (!enabled || storeNow) begin
      pulseCnt_reg <= '0;
      pending_reg  <= 1'b0;
    end else if (rise && seqCnt_reg >= CW'(INIT_CYCLES)) begin
      if (pulseCnt_reg != '1) pulseCnt_reg <= pulseCnt_reg + 1'b1;
      pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_reg    <= LEVEL_DEFAULT;
      discharge_reg <= DISCHARGE_DEFAULT;
    end else if (state_reg == OFF && !(ctrlLine && stopped_reg)) begin
      target_reg <= LEVEL_DEFAULT;
    end else if (storeNow) begin
      if (pulseCnt_reg != '0 && pulseCnt_reg <= CODE_LEVEL_MAX)
        target_reg <= 5'(pulseCnt_reg - 6'h01);
      else if (pulseCnt_reg == CODE_FLOAT) discharge_reg <= 1'b0;
      else if (pulseCnt_reg == CODE_DISCHARGE) discharge_reg <= 1'b1;
      // other counts leave settings alone
    end
  end

  // one 0.1 V step per slice of the transition time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_reg   <= LEVEL_DEFAULT;
      rampCnt_reg <= '0;
    end else if (state_reg != RUN && state_reg != NEG_START) begin
      level_reg   <= target_reg;
      rampCnt_reg <= '0;
    end else if (level_reg != target_reg) begin
      if (rampCnt_reg + 1'b1 >= CW'(TRANS_CYC / 30)) begin
        rampCnt_reg <= '0;
        level_reg <= level_reg < target_reg ? level_reg + 1'b1 : level_reg - 1'b1;
      end else begin
        rampCnt_reg <= rampCnt_reg + 1'b1;
      end
    end else begin
      rampCnt_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive        <= '{posEnable: 1'b0, posSoftLimit: 1'b0, posHighSideOff: 1'b0,
                        negEnable: 1'b0, negLevel: LEVEL_DEFAULT, negRamping: 1'b0,
                        dischargeOn: DISCHARGE_DEFAULT};
      faultLatched <= 1'b0;
      outputsFloat <= 1'b0;
    end else begin
      drive.posEnable      <= enabled;
      drive.posSoftLimit   <= state_reg == POS_START;
      drive.posHighSideOff <= enabled && nearPosRail;
      drive.negEnable      <= state_reg == NEG_START || state_reg == RUN;
      drive.negLevel       <= level_reg;
      drive.negRamping     <= level_reg != target_reg;
      drive.dischargeOn    <= !enabled && discharge_reg;
      faultLatched         <= state_reg == FAULT;
      outputsFloat         <= !enabled && !discharge_reg;
    end
  end
endmodule
`default_nettype wire

// file: verif/drpc_core_sva.sv
/*
  Checker for drpc_core, watching only its ports.
  Assumes the bind at the foot and the shortened cycle counts of the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module drpc_core_sva
  import drpc_pkg::*;
(
  input wire logic                  clk,           // clock
  input wire logic                  reset,         // async reset
  input wire logic                  ctrlLine,      // control line
  input wire logic                  supplyLockout, // lockout
  input wire logic                  nearPosRail,   // diode mode
  input wire drpc_pkg::drpc_sense_t sense,         // comparators
  input wire drpc_pkg::drpc_drive_t drive,         // converter controls
  input wire logic                  faultLatched,  // latched fault
  input wire logic                  outputsFloat   // float mode
);
  logic [9:0] lowCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // consecutive low samples of the line
  always_ff @(posedge clk or posedge reset) begin
    if (reset) lowCnt <= 10'h000;
    else if (ctrlLine) lowCnt <= 10'h000;
    else if (lowCnt != 10'h3ff) lowCnt <= lowCnt + 10'h001;
  end
  property p_line_off; lowCnt > 10'd305 |-> !drive.posEnable && !drive.negEnable; endproperty
  a_line_off: assert property (p_line_off) else $error("line low but enabled");
  property p_lockout; supplyLockout [*4] |-> !drive.posEnable && !drive.negEnable; endproperty
  a_lockout: assert property (p_lockout) else $error("enabled in lockout");
  property p_soft; $rose(drive.posEnable) |-> drive.posSoftLimit && !drive.negEnable; endproperty
  a_soft: assert property (p_soft) else $error("positive start order wrong");
  property p_neg_late; $rose(drive.negEnable) |-> $past(drive.posEnable, 90); endproperty
  a_neg_late: assert property (p_neg_late) else $error("negative started early");
  property p_ramp;
    // while idle the level snaps to the stored target, so only a running rail must ramp
    drive.negEnable && $past(drive.negEnable) && $changed(drive.negLevel) |->
      (5'(drive.negLevel - $past(drive.negLevel)) inside {5'h01, 5'h1f})
      ##1 $stable(drive.negLevel) [*8];
  endproperty
  a_ramp: assert property (p_ramp) else $error("level jump");
  property p_fault_off; faultLatched [*3] |-> !drive.posEnable && !drive.negEnable; endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault not disconnected");
  property p_fault_hold; (ctrlLine && !supplyLockout) [*4] ##0 faultLatched |=> faultLatched;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early");
  property p_diode; nearPosRail [*4] ##0 drive.posEnable |-> drive.posHighSideOff; endproperty
  a_diode: assert property (p_diode) else $error("high side not off");
endmodule
bind drpc_core drpc_core_sva chk (.clk(clk), .reset(reset), .ctrlLine(ctrlLine),
  .supplyLockout(supplyLockout), .nearPosRail(nearPosRail), .sense(sense), .drive(drive),
  .faultLatched(faultLatched), .outputsFloat(outputsFloat));
`default_nettype wire

// file: verif/drpc_host_model.sv
/*
  Host side of the single control line: enable, pulse trains, shutdown.
  Assumes a 100 ns clock; drives 1 ns after each rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module drpc_host_model (
  input  wire logic clk,      // system clock
  output var  logic ctrlLine  // line to device
);
  localparam int PULSE_CYC = 100;
  initial ctrlLine = 1'b0;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic enable();
    ctrlLine = 1'b1;
  endtask
  // n rising edges, each half 10 us, then held high past store
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      ctrlLine = 1'b0;
      wait_cyc(PULSE_CYC);
      ctrlLine = 1'b1;
      wait_cyc(PULSE_CYC);
    end
    wait_cyc(400);
  endtask
  task automatic shut();
    ctrlLine = 1'b0;
    wait_cyc(2000);
  endtask
endmodule
`default_nettype wire

// file: verif/tb_display_rail_pulse_control.sv
/*
  Self-checking bench for drpc_core with shortened start-up counts.
  Assumes the host model drives the line; sense inputs set by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_display_rail_pulse_control;
  import drpc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ctrlLine;
  logic        supplyLockout = 1'b0;
  logic        nearPosRail = 1'b0;
  drpc_sense_t sense = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  drpc_drive_t drive;
  logic        faultLatched;
  logic        outputsFloat;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #50 clk = ~clk;
  drpc_host_model host (.clk(clk), .ctrlLine(ctrlLine));
  drpc_core #(.NEG_DELAY_CYCLES(100), .RUN_FAULT_CYCLES(30), .POS_CHECK_CYCLES(100),
    .NEG_SC_CHECK_CYCLES(100), .NEG_REG_CHECK_CYCLES(200)) DUT (.clk(clk), .reset(reset),
    .ctrlLine(ctrlLine), .supplyLockout(supplyLockout), .nearPosRail(nearPosRail),
    .sense(sense), .drive(drive), .faultLatched(faultLatched), .outputsFloat(outputsFloat));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_startup();
    host.enable();
    host.wait_cyc(4);
    check("posEnable", 8'h01, 8'(drive.posEnable));
    check("posSoftLimit", 8'h01, 8'(drive.posSoftLimit));
    host.wait_cyc(50);
    check("negEnable early", 8'h00, 8'(drive.negEnable));
    host.wait_cyc(60);
    check("negEnable", 8'h01, 8'(drive.negEnable));
    check("default level", 8'h16, 8'(drive.negLevel));
    host.pulses(3);
    check("level in init", 8'h16, 8'(drive.negLevel));
    host.wait_cyc(2500);
    $display("t_startup done");
  endtask
  task automatic t_levels();
    int codes[4] = '{4, 31, 1, 40};
    logic [7:0] exp[4] = '{8'h03, 8'h1e, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host.pulses(codes[i]);
      host.wait_cyc(3200);
      check("negLevel", exp[i], 8'(drive.negLevel));
    end
    nearPosRail = 1'b1;
    host.wait_cyc(6);
    check("posHighSideOff", 8'h01, 8'(drive.posHighSideOff));
    nearPosRail = 1'b0;
    $display("t_levels done");
  endtask
  task automatic t_runfault();
    sense.posLow = 1'b1;
    host.wait_cyc(20);
    sense.posLow = 1'b0;
    host.wait_cyc(2);
    check("short glitch", 8'h00, 8'(faultLatched));
    sense.negHigh = 1'b1;
    host.wait_cyc(40);
    sense.negHigh = 1'b0;
    check("run fault", 8'h01, 8'(faultLatched));
    host.wait_cyc(20);
    check("fault held", 8'h01, 8'(faultLatched));
    check("disconnected", 8'h00, 8'(drive.posEnable));
    host.shut();
    check("discharge default", 8'h01, 8'(drive.dischargeOn));
    $display("t_runfault done");
  endtask
  task automatic t_modes();
    logic [7:0] exp[2] = '{8'h01, 8'h00};
    for (int i = 0; i < 2; i++) begin
      host.enable();
      host.wait_cyc(3100);
      check("fault cleared", 8'h00, 8'(faultLatched));
      host.pulses(50 + i);
      host.shut();
      check("outputsFloat", exp[i], 8'(outputsFloat));
    end
    $display("t_modes done");
  endtask
  task automatic t_startfaults();
    for (int i = 0; i < 3; i++) begin
      if (i == 0) sense.posInReg = 1'b0;
      if (i == 1) sense.negAboveSc = 1'b1;
      if (i == 2) sense.negInReg = 1'b0;
      host.enable();
      host.wait_cyc(230);
      check("start fault", 8'h01, 8'(faultLatched));
      check("start off", 8'h00, 8'(drive.negEnable));
      sense = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      host.shut();
    end
    host.enable();
    host.wait_cyc(230);
    check("clean start", 8'h00, 8'(faultLatched));
    sense.posLow = 1'b1;
    host.wait_cyc(40);
    sense.posLow = 1'b0;
    check("pos run fault", 8'h01, 8'(faultLatched));
    supplyLockout = 1'b1;
    host.wait_cyc(6);
    check("lockout", 8'h00, 8'(drive.posEnable));
    check("lockout clears fault", 8'h00, 8'(faultLatched));
    $display("t_startfaults done");
  endtask
  initial begin
    host.wait_cyc(6);
    reset = 1'b0;
    t_startup();
    t_levels();
    t_runfault();
    t_modes();
    t_startfaults();
    print_verdict();
  end
  initial begin
    #9000000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
